/* File: core/acr_consts.svh */
// Offsets, field positions, reset values and timing counts of the converter
// control block. Assumes inclusion by bare name from the control module and the testbench.
//
// Functional notes
// - Reference select bits 7:6 choose reference source
// - Reference and channel changes made during a conversion apply at completion; changes while idle apply at once
// - Left adjust bit 5 selects result justification
// - Justification change shows immediately in result bytes
// - Channel codes select single-ended inputs, bandgap, ground
// - Channel codes select differential pairs
// - Enable bit powers converter; clearing aborts conversion
// - Start bit launches conversion; free running once
// - First conversion 25 clocks, later 13
// - Start reads one while busy; zero write ignored
// - Auto trigger starts on trigger rising edge
// - Done flag sets at each completion, even while a locked result is held
// - Interrupt needs flag, enable and global enable
// - Done flag cleared by vector or writing one
// - Both registers reset zero, read-write except the start and done flag bits
// - Divider codes give divide by 2 to 128
// - Low byte read locks result until high read
// - Switching to free running makes no trigger
`ifndef ACR_CONSTS_SVH
`define ACR_CONSTS_SVH

// Register byte addresses.
`define ACR_ADDR_CTRL      8'h7A
`define ACR_ADDR_CTRL_B    8'h7B
`define ACR_ADDR_MUX       8'h7C
`define ACR_ADDR_RES_LOW   8'h78
`define ACR_ADDR_RES_HIGH  8'h79

// Control register fields.
`define ACR_CTRL_EN        7
`define ACR_CTRL_START     6
`define ACR_CTRL_AUTO      5
`define ACR_CTRL_DONE      4
`define ACR_CTRL_IE        3

// Input select fields.
`define ACR_MUX_LADJ       5

// Reset values.
`define ACR_RESET_BYTE     8'h00

// Conversion lengths in converter clock cycles.
`define ACR_FIRST_CYCLES   5'h19
`define ACR_NORM_CYCLES    5'h0D

// Trigger source code for free running.
`define ACR_TRIG_FREE      3'h0

`endif

/* File: core/acr_pkg.sv */
// Types shared by the converter control modules.
// Assumes acr_consts.svh is on the include path.
`default_nettype none
package acr_pkg;
  // Conversion sequencer states, one-hot.
  typedef enum logic [2:0] {
    ACR_IDLE  = 3'b001,
    ACR_CONV  = 3'b010,
    ACR_DONE  = 3'b100
  } acr_state_t;
endpackage : acr_pkg
`default_nettype wire

/* File: core/acr_div_if.sv */
// Interface between the control top and its prescaler.
// Assumes both ends run on one clock.
`timescale 1ns/1ps
`default_nettype none
interface acr_div_if;
  logic [2:0] sel;
  logic       run;
  logic       tick;
  modport ctrl (output sel, output run, input tick);
  modport div  (input sel, input run, output tick);
endinterface : acr_div_if
`default_nettype wire

/* File: core/acr_prescaler.sv */
// Converter clock prescaler: one-cycle tick per converter clock period.
// Assumes the interface is driven from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module acr_prescaler (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  // Control side
  acr_div_if.div    dv
);
  logic [6:0] cnt_reg;
  logic [6:0] cnt_next;
  logic [6:0] limit;
  logic       hit;

  // Divide by two for codes 0 and 1, doubling each code after.
  assign limit = (dv.sel == 3'h0) ? 7'h01 : 7'((8'h01 << dv.sel) - 8'h01);
  assign hit = dv.run && (cnt_reg >= limit);
  assign cnt_next = (!dv.run || hit) ? 7'h00 : 7'(cnt_reg + 7'h01);
  assign dv.tick = hit;

  // Counter restarts whenever the converter is idle.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_reg <= 7'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // A tick never comes closer than two system clocks.
  tick_space_a: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    dv.tick |=> !dv.tick)
    else $error("Prescaler tick too frequent.");
endmodule : acr_prescaler
`default_nettype wire

/* File: core/acr_ctrl.sv */
// Converter control and status registers with conversion sequencer.
// Assumes a plain register port, a trigger from same-clock logic and a
// 10-bit result from the analog converter when its sample ends.
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "acr_consts.svh"
module acr_ctrl
  import acr_pkg::*;
#(
  parameter int RES_W = 10
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             arst_n_in,
  // Register port
  input  wire logic [7:0]       addr_in,
  input  wire logic [7:0]       wdata_in,
  input  wire logic             wr_in,
  input  wire logic             rd_in,
  output logic      [7:0]       rdata_out,
  // System side
  input  wire logic             global_ie_in,
  input  wire logic             vector_ack_in,
  input  wire logic             trigger_in,
  output logic                  irq_out,
  // Analog side
  input  wire logic [RES_W-1:0] sample_in,
  output logic                  power_up_out,
  output logic      [1:0]       ref_select_out,
  output logic      [4:0]       channel_select_out,
  output logic                  sampling_out,
  output logic                  init_out
);

  ////////////////////////////////////////////////////////////////////////
  // Registers and state.
  logic [7:0]       mux_reg;
  logic [7:0]       ctrl_reg;
  logic [7:0]       ctrl_next;
  logic [2:0]       trig_src_reg;
  logic [RES_W-1:0] result_reg;
  logic [RES_W-1:0] result_next;
  logic             lock_reg;
  logic             first_reg;
  logic             trig_old_reg;
  logic [4:0]       cyc_reg;
  logic [4:0]       cyc_next;
  logic [4:0]       cyc_len_reg;
  logic [1:0]       ref_reg;
  logic [4:0]       chan_reg;
  logic [7:0]       rdata_next;
  acr_state_t       state_reg;
  acr_state_t       state_next;
  acr_div_if        dv ();

  ////////////////////////////////////////////////////////////////////////
  // Decode of register accesses.
  logic             wr_ctrl;
  logic             wr_mux;
  logic             wr_ctrl_b;
  logic             rd_low;
  logic             rd_high;
  logic             en_now;
  logic             auto_now;
  logic             free_mode;
  logic             sw_start;
  logic             trig_rise;
  logic             start_go;
  logic             conv_end;
  logic             busy;
  logic             abort;
  logic             len_first;
  assign wr_ctrl   = wr_in && (addr_in == `ACR_ADDR_CTRL);
  assign wr_mux    = wr_in && (addr_in == `ACR_ADDR_MUX);
  assign wr_ctrl_b = wr_in && (addr_in == `ACR_ADDR_CTRL_B);
  assign rd_low    = rd_in && (addr_in == `ACR_ADDR_RES_LOW);
  assign rd_high   = rd_in && (addr_in == `ACR_ADDR_RES_HIGH);

  // Enable and start seen in the same cycle as a control write.
  assign en_now    = wr_ctrl ? wdata_in[`ACR_CTRL_EN] : ctrl_reg[`ACR_CTRL_EN];
  assign auto_now  = ctrl_reg[`ACR_CTRL_AUTO];
  assign free_mode = auto_now && (trig_src_reg == `ACR_TRIG_FREE);
  assign sw_start  = wr_ctrl && wdata_in[`ACR_CTRL_START];
  // Rising edge of the trigger; free running ignores it entirely.
  assign trig_rise = auto_now && !free_mode && trigger_in && !trig_old_reg;
  assign busy      = (state_reg == ACR_CONV);
  assign abort     = busy && !en_now;
  assign conv_end  = busy && dv.tick && (cyc_reg == cyc_len_reg - 5'h01);
  // Free running restarts on completion while enabled.
  assign start_go  = en_now && !busy &&
                     (sw_start || trig_rise ||
                      (free_mode && state_reg == ACR_DONE));

  ////////////////////////////////////////////////////////////////////////
  // Sequencer next state.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ACR_IDLE: begin
        if (start_go) state_next = ACR_CONV;
      end
      ACR_CONV: begin
        if (abort) state_next = ACR_IDLE;
        else if (conv_end) state_next = ACR_DONE;
      end
      ACR_DONE: begin
        state_next = start_go ? ACR_CONV : ACR_IDLE;
      end
      default: state_next = ACR_IDLE;
    endcase
  end

  // Cycle counter advances on each converter clock tick.
  assign cyc_next = (!busy || conv_end) ? 5'h00 :
                    (dv.tick ? 5'(cyc_reg + 5'h01) : cyc_reg);

  // Prescaler runs only while a conversion is in progress.
  assign dv.sel = ctrl_reg[2:0];
  assign dv.run = busy && !abort;
  acr_prescaler u_div (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .dv        (dv.div)
  );

  ////////////////////////////////////////////////////////////////////////
  // Control register next value.
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next[7]   = wdata_in[7];
      ctrl_next[5]   = wdata_in[5];
      ctrl_next[3:0] = wdata_in[3:0];
      // Writing one clears the flag; zero leaves it.
      if (wdata_in[`ACR_CTRL_DONE]) ctrl_next[`ACR_CTRL_DONE] = 1'b0;
    end
    if (vector_ack_in) ctrl_next[`ACR_CTRL_DONE] = 1'b0;
    // Completion sets the flag and wins over any clear.
    if (conv_end && !abort) ctrl_next[`ACR_CTRL_DONE] = 1'b1;
    // Start reads one exactly while converting.
    ctrl_next[`ACR_CTRL_START] = (state_next == ACR_CONV);
  end

  // Result update is held while the low byte has been read.
  assign result_next = (conv_end && !abort && !lock_reg) ? sample_in
                                                          : result_reg;

  ////////////////////////////////////////////////////////////////////////
  // Read data: result justification follows the live bit.
  logic [15:0] res_view;
  assign res_view = mux_reg[`ACR_MUX_LADJ] ?
                    {result_reg, {(16-RES_W){1'b0}}} :
                    {{(16-RES_W){1'b0}}, result_reg};
  always_comb begin
    case (addr_in)
      `ACR_ADDR_CTRL:     rdata_next = ctrl_reg;
      `ACR_ADDR_CTRL_B:   rdata_next = {5'h00, trig_src_reg};
      `ACR_ADDR_MUX:      rdata_next = mux_reg;
      `ACR_ADDR_RES_LOW:  rdata_next = res_view[7:0];
      `ACR_ADDR_RES_HIGH: rdata_next = res_view[15:8];
      default:            rdata_next = `ACR_RESET_BYTE;
    endcase
    if (!rd_in) rdata_next = `ACR_RESET_BYTE;
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file and sequencer flops; all reset to zero except the state, which resets to ACR_IDLE.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mux_reg      <= `ACR_RESET_BYTE;
      ctrl_reg     <= `ACR_RESET_BYTE;
      trig_src_reg <= 3'h0;
      state_reg    <= ACR_IDLE;
      cyc_reg      <= 5'h00;
      trig_old_reg <= 1'b0;
      rdata_out    <= `ACR_RESET_BYTE;
    end else begin
      if (wr_mux) mux_reg <= wdata_in;
      if (wr_ctrl_b) trig_src_reg <= wdata_in[2:0];
      ctrl_reg     <= ctrl_next;
      state_reg    <= state_next;
      cyc_reg      <= cyc_next;
      trig_old_reg <= trigger_in;
      rdata_out    <= rdata_next;
    end
  end

  // Result, lock and first-conversion tracking.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      result_reg <= '0;
      lock_reg   <= 1'b0;
      first_reg  <= 1'b1;
    end else begin
      result_reg <= result_next;
      if (rd_high) lock_reg <= 1'b0;
      else if (rd_low) lock_reg <= 1'b1;
      // Disabled converter needs initialisation again.
      if (!en_now) first_reg <= 1'b1;
      else if (start_go) first_reg <= 1'b0;
    end
  end

  // Length, reference and channel latched at each start.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cyc_len_reg <= `ACR_NORM_CYCLES;
      ref_reg     <= 2'h0;
      chan_reg    <= 5'h00;
    end else if (start_go) begin
      cyc_len_reg <= first_reg ? `ACR_FIRST_CYCLES : `ACR_NORM_CYCLES;
      ref_reg     <= mux_reg[7:6];
      chan_reg    <= mux_reg[4:0];
    end else if (!busy) begin
      ref_reg  <= mux_reg[7:6];
      chan_reg <= mux_reg[4:0];
    end
  end

  // Initialisation flag follows the length chosen at the start edge, since
  // the latched length only becomes valid one cycle later.
  assign len_first = start_go ? first_reg
                              : (cyc_len_reg == `ACR_FIRST_CYCLES);

  // Outputs to the analog side and interrupt.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_out            <= 1'b0;
      power_up_out       <= 1'b0;
      ref_select_out     <= 2'h0;
      channel_select_out <= 5'h00;
      sampling_out       <= 1'b0;
      init_out           <= 1'b0;
    end else begin
      irq_out <= ctrl_next[`ACR_CTRL_DONE] &&
                 ctrl_next[`ACR_CTRL_IE] && global_ie_in;
      power_up_out       <= ctrl_next[`ACR_CTRL_EN];
      ref_select_out     <= ref_reg;
      channel_select_out <= chan_reg;
      sampling_out       <= (state_next == ACR_CONV);
      init_out           <= (state_next == ACR_CONV) && len_first;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  done_sets_a: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    conv_end && !abort |=> ctrl_reg[`ACR_CTRL_DONE])
    else $error("Done flag did not set at completion.");
  start_busy_a: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    ctrl_reg[`ACR_CTRL_START] == busy)
    else $error("Start bit disagrees with busy.");
  abort_stop_a: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    abort |=> state_reg == ACR_IDLE &&
              (!ctrl_reg[`ACR_CTRL_DONE] || $past(ctrl_reg[`ACR_CTRL_DONE])))
    else $error("Disable did not abort conversion.");
  irq_gate_a: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    irq_out |-> ctrl_reg[`ACR_CTRL_DONE] && ctrl_reg[`ACR_CTRL_IE])
    else $error("Interrupt without flag and enable.");
  clear_one_a: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    wr_ctrl && wdata_in[4] && !conv_end |=> !ctrl_reg[4])
    else $error("Write one did not clear done flag.");
  lock_hold_a: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    lock_reg && !rd_high |=> result_reg == $past(result_reg))
    else $error("Result changed while locked.");
  chan_hold_a: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    busy && $past(busy) |-> $stable(chan_reg) && $stable(ref_reg))
    else $error("Selection changed during conversion.");
  free_edge_a: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    free_mode && state_reg == ACR_IDLE && !sw_start |=> state_reg != ACR_CONV)
    else $error("Free running started without software.");
  len_ok_a: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    busy |-> cyc_len_reg == `ACR_FIRST_CYCLES ||
             cyc_len_reg == `ACR_NORM_CYCLES)
    else $error("Conversion length is wrong.");
  first_len_a: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    start_go && first_reg |=> cyc_len_reg == `ACR_FIRST_CYCLES)
    else $error("First conversion is not the long one.");
  init_len_a: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    sampling_out |-> init_out == (cyc_len_reg == `ACR_FIRST_CYCLES))
    else $error("Initialisation flag disagrees with length.");
  ladj_view_a: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    rd_high && mux_reg[`ACR_MUX_LADJ]
    |=> rdata_out == $past(result_reg[RES_W-1:RES_W-8]))
    else $error("Left adjusted high byte is wrong.");
  trig_start_a: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    trig_rise && en_now && state_reg == ACR_IDLE |=> state_reg == ACR_CONV)
    else $error("Trigger edge did not start a conversion.");
  free_restart_a: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    free_mode && en_now && state_reg == ACR_DONE |=> state_reg == ACR_CONV)
    else $error("Free running did not restart.");
  conv_cv: cover property (@(posedge clk_in) disable iff (!arst_n_in)
    conv_end && cyc_len_reg == `ACR_FIRST_CYCLES);
  free_cv: cover property (@(posedge clk_in) disable iff (!arst_n_in)
    free_mode && state_reg == ACR_DONE && start_go);
  abort_cv: cover property (@(posedge clk_in) disable iff (!arst_n_in)
    abort);
  trig_cv: cover property (@(posedge clk_in) disable iff (!arst_n_in)
    trig_rise && start_go);
  lock_cv: cover property (@(posedge clk_in) disable iff (!arst_n_in)
    conv_end && lock_reg);
endmodule : acr_ctrl
`default_nettype wire

/* File: sim/acr_analog_model.sv */
// Behavioural model of the analog inputs and reference behind the block.
// Assumes select lines come from the block on the same clock.
`timescale 1ns/1ps
`default_nettype none
module acr_analog_model (
  // Clock
  input  wire logic       clk_in,
  // Block side
  input  wire logic       power_up_in,
  input  wire logic [1:0] ref_select_in,
  input  wire logic [4:0] channel_select_in,
  input  wire logic       sampling_in,
  // Result
  output logic      [9:0] sample_out
);
  logic [9:0] last_reg;
  logic       active;
  // Code depends on reference and channel so the selects can be traced.
  assign active = power_up_in & sampling_in;
  assign sample_out = active ? {ref_select_in, channel_select_in, 3'h5}
                             : ~last_reg;
  // Remember the last driven code so an idle line never repeats it.
  always @(posedge clk_in) begin
    if (active) begin
      last_reg <= sample_out;
    end
  end
  initial last_reg = 10'h000;
endmodule : acr_analog_model
`default_nettype wire

/* File: sim/adc_control_registers_test.sv */
// Self-checking bench for the converter control block.
// Assumes acr_consts.svh on the include path and the analog model beside.
`timescale 1ns/1ps
`default_nettype none
`include "acr_consts.svh"
module adc_control_registers_test;
  logic clk = 0, arst_n = 0, wr = 0, rd = 0, gie = 0, vack = 0, trig = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d;
  logic [9:0] smp;
  logic irq, pwr, samp, init;
  logic [1:0] refs;
  logic [4:0] chan;
  int n_mismatch = 0, comparisons = 0, cyc = 0, t0;
  ////////////////////////////////////////////////////////////////////////
  // Clock, cycle count and design.
  initial forever #2 clk = ~clk;
  always @(posedge clk) cyc++;
  acr_ctrl i_dut (.clk_in(clk), .arst_n_in(arst_n), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .global_ie_in(gie), .vector_ack_in(vack), .trigger_in(trig),
    .irq_out(irq), .sample_in(smp), .power_up_out(pwr),
    .ref_select_out(refs), .channel_select_out(chan),
    .sampling_out(samp), .init_out(init));
  acr_analog_model i_ana (.clk_in(clk), .power_up_in(pwr),
    .ref_select_in(refs), .channel_select_in(chan), .sampling_in(samp),
    .sample_out(smp));
  ////////////////////////////////////////////////////////////////////////
  // Bus tasks, comparison and closing.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Waits a bounded time for the sampling output to reach a level.
  task automatic wait_samp(input logic lvl, input int max);
    int n;
    n = 0;
    while (samp !== lvl && n < max) begin
      @(posedge clk);
      #1 n++;
    end
  endtask : wait_samp
  // Expected analog code for a reference and channel.
  function automatic logic [9:0] ex(input logic [1:0] r,
                                    input logic [4:0] c);
    return {r, c, 3'h5};
  endfunction : ex
  task automatic test_done;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  initial begin
    #80000;
    n_mismatch++;
    test_done();
  end
  ////////////////////////////////////////////////////////////////////////
  // Test sequence.
  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    rd_reg(`ACR_ADDR_CTRL, d); chk("ctrl_rst", 8'h00, d);
    rd_reg(`ACR_ADDR_MUX, d); chk("mux_rst", 8'h00, d);
    rd_reg(8'h10, d); chk("unmapped", 8'h00, d);
    wr_reg(`ACR_ADDR_CTRL, 8'h2F);
    rd_reg(`ACR_ADDR_CTRL, d); chk("ctrl_rw", 8'h2F, d);
    wr_reg(`ACR_ADDR_CTRL, 8'h40);
    rd_reg(`ACR_ADDR_CTRL, d); chk("start_off", 8'h00, d);
    wr_reg(`ACR_ADDR_MUX, 8'hD3);
    rd_reg(`ACR_ADDR_MUX, d); chk("mux_rw", 8'hD3, d);
    chk("ref_out", 8'h03, {6'h00, refs});
    chk("chan_out", 8'h13, {3'h0, chan});
    // First conversion after enabling runs the long sequence.
    wr_reg(`ACR_ADDR_CTRL, 8'hC0);
    t0 = cyc;
    chk("init", 8'h01, {7'h00, init});
    chk("power", 8'h01, {7'h00, pwr});
    rd_reg(`ACR_ADDR_CTRL, d); chk("busy_rd", 8'hC0, d);
    wr_reg(`ACR_ADDR_MUX, 8'h1E);
    chk("chan_hold", 8'h13, {3'h0, chan});
    wait_samp(1'b0, 200);
    chk("len25", 8'h01, {7'h00, (cyc - t0) inside {[48:52]}});
    rd_reg(`ACR_ADDR_CTRL, d); chk("done_rd", 8'h90, d);
    chk("chan_new", 8'h1E, {3'h0, chan});
    rd_reg(`ACR_ADDR_RES_LOW, d);
    chk("res_lo", 8'(ex(3, 19)), d);
    rd_reg(`ACR_ADDR_RES_HIGH, d);
    chk("res_hi", 8'(ex(3, 19) >> 8), d);
    wr_reg(`ACR_ADDR_MUX, 8'h3E);
    rd_reg(`ACR_ADDR_RES_LOW, d);
    chk("lres_lo", 8'({ex(3, 19), 6'h00}), d);
    rd_reg(`ACR_ADDR_RES_HIGH, d);
    chk("lres_hi", 8'(ex(3, 19) >> 2), d);
    // Interrupt gating and flag clearing; whole-byte writes only.
    wr_reg(`ACR_ADDR_CTRL, 8'h88);
    rd_reg(`ACR_ADDR_CTRL, d); chk("flag_keep", 8'h98, d);
    chk("irq_gie0", 8'h00, {7'h00, irq});
    gie <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("irq_on", 8'h01, {7'h00, irq});
    vack <= 1'b1;
    @(posedge clk);
    vack <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("irq_ack", 8'h00, {7'h00, irq});
    // Later conversion is short; divider code 1 still halves the clock.
    wr_reg(`ACR_ADDR_CTRL, 8'hC9);
    t0 = cyc;
    wait_samp(1'b0, 200);
    chk("len13", 8'h01, {7'h00, (cyc - t0) inside {[24:28]}});
    repeat (2) @(posedge clk);
    #1 chk("irq_done", 8'h01, {7'h00, irq});
    wr_reg(`ACR_ADDR_CTRL, 8'h98);
    rd_reg(`ACR_ADDR_CTRL, d); chk("flag_clr", 8'h88, d);
    gie <= 1'b0;
    // Low byte read holds the result through another conversion.
    rd_reg(`ACR_ADDR_RES_LOW, d);
    // Divider code 2 quarters the clock for this conversion.
    wr_reg(`ACR_ADDR_MUX, 8'hC5);
    wr_reg(`ACR_ADDR_CTRL, 8'hC2);
    t0 = cyc;
    wait_samp(1'b0, 200);
    chk("len_div4", 8'h01, {7'h00, (cyc - t0) inside {[50:54]}});
    rd_reg(`ACR_ADDR_RES_HIGH, d);
    chk("lock_hi", 8'(ex(0, 30) >> 8), d);
    // Disabling mid-conversion aborts it; the one in bit 4 clears the flag
    // left by the locked conversion, so no flag may stand afterwards.
    wr_reg(`ACR_ADDR_CTRL, 8'hC0);
    repeat (6) @(posedge clk);
    wr_reg(`ACR_ADDR_CTRL, 8'h10);
    chk("abort", 8'h00, {6'h00, pwr, samp});
    rd_reg(`ACR_ADDR_CTRL, d); chk("abort_rd", 8'h00, d);
    // Free running restarts by itself.
    wr_reg(`ACR_ADDR_CTRL_B, 8'h00);
    wr_reg(`ACR_ADDR_CTRL, 8'hE0);
    wait_samp(1'b0, 200);
    wait_samp(1'b1, 4);
    chk("free_run", 8'h01, {7'h00, samp});
    wr_reg(`ACR_ADDR_CTRL, 8'h00);
    // Auto trigger on a rising edge, then no trigger on mode switch.
    wr_reg(`ACR_ADDR_CTRL_B, 8'h01);
    wr_reg(`ACR_ADDR_CTRL, 8'hA0);
    trig <= 1'b1;
    wait_samp(1'b1, 4);
    chk("trig_start", 8'h01, {7'h00, samp});
    trig <= 1'b0;
    wait_samp(1'b0, 200);
    wr_reg(`ACR_ADDR_CTRL_B, 8'h00);
    repeat (4) @(posedge clk);
    #1 chk("no_trig", 8'h00, {7'h00, samp});
    test_done();
  end
endmodule : adc_control_registers_test
`default_nettype wire
